// ===== rtl/rotate_subtract_skip_alu.sv
// Rotate, subtract, skip and set datapath with an AHB-Lite register slave
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`include "alu_params.svh"
module rotate_subtract_skip_alu (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // Decoder request and memory read data
  input  wire alu_pkg::exec_req_type exec_req,
  input  wire logic [7:0]            mem_rdata,
  // Sequencer and memory side
  output logic                       exec_ready,
  output logic                       flush,
  output logic                       mem_we,
  output logic [7:0]                 mem_wdata,
  output logic [7:0]                 working_register,
  output alu_pkg::flags_type         flags
);

  alu_pkg::state_type s_r;
  alu_pkg::state_type s_nxt;

  logic       fire;
  logic       bus_take;
  logic [7:0] m;
  logic [7:0] w;
  logic       cin;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] diff;
  logic [7:0] rol_v;
  logic [7:0] rlc_v;
  logic [7:0] ror_v;
  logic [7:0] rrc_v;
  logic [7:0] dec_v;
  logic [7:0] inc_v;
  logic [7:0] bit_mask;
  logic       bit_hit;
  logic       borrow_op;
  logic       sub_op;
  logic       sub_ov;

  // Request is taken only while not in a dummy cycle
  assign fire     = exec_req.valid && s_r.ready;
  assign bus_take = hsel && hready && htrans[1];
  assign m        = mem_rdata;
  assign w        = s_r.work;

  // Rotations, plain and through carry
  assign rol_v = {m[6:0], m[7]}; // RULE1
  assign rlc_v = {m[6:0], s_r.flags.c}; // RULE3
  assign ror_v = {m[0], m[7:1]}; // RULE5
  assign rrc_v = {s_r.flags.c, m[7:1]}; // RULE7

  // Subtraction as addition of the inverted operand
  assign borrow_op = (exec_req.op == alu_pkg::OP_BORROW_MINUS_TO_WORKING) ||
                     (exec_req.op == alu_pkg::OP_BORROW_MINUS_TO_MEMORY);
  assign sub_op    = borrow_op ||
                     (exec_req.op == alu_pkg::OP_MINUS_TO_WORKING) ||
                     (exec_req.op == alu_pkg::OP_MINUS_TO_MEMORY);
  assign cin  = borrow_op ? s_r.flags.c : 1'b1; // RULE9 RULE10
  assign sum9 = {1'b0, w} + {1'b0, ~m} + {8'h00, cin};
  assign nib5 = {1'b0, w[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cin}; // RULE19
  assign diff = sum9[7:0];
  assign sub_ov = (w[7] == ~m[7]) && (diff[7] != w[7]); // RULE19

  // Increment, decrement and bit select
  assign dec_v    = m - 8'h01; // RULE11
  assign inc_v    = m + 8'h01; // RULE13
  assign bit_mask = 8'h01 << exec_req.bit_sel;
  assign bit_hit  = m[exec_req.bit_sel]; // RULE15

  // Next state: bus slave, then datapath, then sequencing
  always_comb begin
    s_nxt        = s_r;
    s_nxt.mem_we = 1'b0;
    s_nxt.flush  = 1'b0;
    s_nxt.hreadyout = 1'b1;
    // Address phase of a transfer
    s_nxt.wr_pend = bus_take && hwrite;
    if (bus_take) begin
      s_nxt.wr_idx = haddr[`ADDR_MSB:`ADDR_LSB];
    end
    if (bus_take && !hwrite) begin
      case (haddr[`ADDR_MSB:`ADDR_LSB])
        `WORK_OFS:  s_nxt.rdata = {24'h000000, s_r.work};
        `FLAGS_OFS: s_nxt.rdata = {28'h0000000, s_r.flags};
        `STAT_OFS:  s_nxt.rdata = {30'h00000000, s_r.last_skip,
                                   (s_r.fsm == alu_pkg::DUMMY)};
        default:    s_nxt.rdata = 32'h00000000;
      endcase
    end
    // Data phase of a write
    if (s_r.wr_pend) begin
      case (s_r.wr_idx)
        `WORK_OFS:  s_nxt.work  = hwdata[7:0];
        `FLAGS_OFS: s_nxt.flags = hwdata[3:0];
        default:    s_nxt.work  = s_nxt.work;
      endcase
    end
    // Datapath; it wins over a bus write in the same cycle
    if (fire) begin
      s_nxt.last_skip = 1'b0;
      case (exec_req.op)
        alu_pkg::OP_ROTATE_LEFT_MEMORY: begin
          s_nxt.mem_we    = 1'b1; // RULE1
          s_nxt.mem_wdata = rol_v;
        end
        alu_pkg::OP_ROTATE_LEFT_TO_WORKING: begin
          s_nxt.work = rol_v; // RULE2
        end
        alu_pkg::OP_ROTATE_LEFT_THRU_CARRY: begin
          s_nxt.mem_we    = 1'b1; // RULE3
          s_nxt.mem_wdata = rlc_v;
          s_nxt.flags.c   = m[7];
        end
        alu_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING: begin
          s_nxt.work    = rlc_v; // RULE4
          s_nxt.flags.c = m[7];
        end
        alu_pkg::OP_ROTATE_RIGHT_MEMORY: begin
          s_nxt.mem_we    = 1'b1; // RULE5
          s_nxt.mem_wdata = ror_v;
        end
        alu_pkg::OP_ROTATE_RIGHT_TO_WORKING: begin
          s_nxt.work = ror_v; // RULE6
        end
        alu_pkg::OP_ROTATE_RIGHT_THRU_CARRY: begin
          s_nxt.mem_we    = 1'b1; // RULE7
          s_nxt.mem_wdata = rrc_v;
          s_nxt.flags.c   = m[0];
        end
        alu_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING: begin
          s_nxt.work    = rrc_v; // RULE8
          s_nxt.flags.c = m[0];
        end
        alu_pkg::OP_BORROW_MINUS_TO_WORKING,
        alu_pkg::OP_MINUS_TO_WORKING: begin
          s_nxt.work = diff; // RULE9 RULE10
        end
        alu_pkg::OP_BORROW_MINUS_TO_MEMORY,
        alu_pkg::OP_MINUS_TO_MEMORY: begin
          s_nxt.mem_we    = 1'b1; // RULE9 RULE10
          s_nxt.mem_wdata = diff;
        end
        alu_pkg::OP_DEC_SKIP_ZERO: begin
          s_nxt.mem_we    = 1'b1; // RULE11
          s_nxt.mem_wdata = dec_v;
          s_nxt.last_skip = (dec_v == 8'h00);
        end
        alu_pkg::OP_DEC_TO_WORKING_SKIP_ZERO: begin
          s_nxt.work      = dec_v; // RULE12
          s_nxt.last_skip = (dec_v == 8'h00);
        end
        alu_pkg::OP_INC_SKIP_ZERO: begin
          s_nxt.mem_we    = 1'b1; // RULE13
          s_nxt.mem_wdata = inc_v;
          s_nxt.last_skip = (inc_v == 8'h00);
        end
        alu_pkg::OP_INC_TO_WORKING_SKIP_ZERO: begin
          s_nxt.work      = inc_v; // RULE14
          s_nxt.last_skip = (inc_v == 8'h00);
        end
        alu_pkg::OP_BIT_SET_SKIP: begin
          s_nxt.last_skip = bit_hit; // RULE15
        end
        alu_pkg::OP_BYTE_SET: begin
          s_nxt.mem_we    = 1'b1; // RULE17
          s_nxt.mem_wdata = 8'hFF;
        end
        alu_pkg::OP_BIT_SET: begin
          s_nxt.mem_we    = 1'b1; // RULE18
          s_nxt.mem_wdata = m | bit_mask;
        end
        default: begin
          s_nxt.mem_we = 1'b0;
        end
      endcase
      // Subtract flags
      if (sub_op) begin
        s_nxt.flags.c  = sum9[8]; // RULE19
        s_nxt.flags.ac = nib5[4];
        s_nxt.flags.ov = sub_ov;
        s_nxt.flags.z  = (diff == 8'h00); // RULE9 RULE10
      end
    end
    // Skip sequencing: flush prefetch, one dummy cycle
    case (s_r.fsm)
      alu_pkg::RUN: begin
        if (fire && s_nxt.last_skip) begin
          s_nxt.fsm   = alu_pkg::DUMMY; // RULE16
          s_nxt.flush = 1'b1;
        end
      end
      alu_pkg::DUMMY: begin
        s_nxt.fsm = alu_pkg::RUN;
      end
      default: begin
        s_nxt.fsm = alu_pkg::RUN;
      end
    endcase
    s_nxt.ready = (s_nxt.fsm == alu_pkg::RUN);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r.fsm       <= alu_pkg::RUN;
      s_r.ready     <= 1'b1;
      s_r.flush     <= 1'b0;
      s_r.last_skip <= 1'b0;
      s_r.work      <= `WORK_RST;
      s_r.flags     <= `FLAGS_RST;
      s_r.mem_we    <= 1'b0;
      s_r.mem_wdata <= 8'h00;
      s_r.wr_pend   <= 1'b0;
      s_r.wr_idx    <= 6'h00;
      s_r.rdata     <= 32'h00000000;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register, except hresp, which is tied low
  assign hreadyout        = s_r.hreadyout;
  assign hrdata           = s_r.rdata;
  assign hresp            = 1'b0;
  assign exec_ready       = s_r.ready;
  assign flush            = s_r.flush;
  assign mem_we           = s_r.mem_we;
  assign mem_wdata        = s_r.mem_wdata;
  assign working_register = s_r.work;
  assign flags            = s_r.flags;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic bus_wr_now;
  assign bus_wr_now = s_r.wr_pend;

  sequence s_go(alu_pkg::op_type o);
    exec_req.valid && exec_ready && (exec_req.op == o) && !bus_wr_now;
  endsequence

  sequence s_keep_flags;
    flags == $past(flags);
  endsequence

  sequence s_keep_work;
    working_register == $past(working_register);
  endsequence

  AST_ROL_MEM: assert property ( // RULE1
    s_go(alu_pkg::OP_ROTATE_LEFT_MEMORY) |=> (mem_we
      && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}) and s_keep_flags)
    else $error("rotate left memory wrong");

  AST_ROL_WORK: assert property ( // RULE2
    s_go(alu_pkg::OP_ROTATE_LEFT_TO_WORKING) |=> (!mem_we
      && working_register == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}) and s_keep_flags)
    else $error("rotate left to working wrong");

  AST_RLC_MEM: assert property ( // RULE3
    s_go(alu_pkg::OP_ROTATE_LEFT_THRU_CARRY) |=> mem_we
      && mem_wdata == {$past(mem_rdata[6:0]), $past(flags.c)}
      && flags.c == $past(mem_rdata[7]) && flags.z == $past(flags.z))
    else $error("rotate left through carry wrong");

  AST_RLC_WORK: assert property ( // RULE4
    s_go(alu_pkg::OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING) |=> !mem_we
      && working_register == {$past(mem_rdata[6:0]), $past(flags.c)}
      && flags.c == $past(mem_rdata[7]))
    else $error("rotate left through carry to working wrong");

  AST_ROR_MEM: assert property ( // RULE5
    s_go(alu_pkg::OP_ROTATE_RIGHT_MEMORY) |=> (mem_we
      && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}) and s_keep_work)
    else $error("rotate right memory wrong");

  AST_ROR_WORK: assert property ( // RULE6
    s_go(alu_pkg::OP_ROTATE_RIGHT_TO_WORKING) |=> (!mem_we
      && working_register == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}) and s_keep_flags)
    else $error("rotate right to working wrong");

  AST_RRC_MEM: assert property ( // RULE7
    s_go(alu_pkg::OP_ROTATE_RIGHT_THRU_CARRY) |=> mem_we
      && mem_wdata == {$past(flags.c), $past(mem_rdata[7:1])}
      && flags.c == $past(mem_rdata[0]))
    else $error("rotate right through carry wrong");

  AST_RRC_WORK: assert property ( // RULE8
    s_go(alu_pkg::OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING) |=> !mem_we
      && working_register == {$past(flags.c), $past(mem_rdata[7:1])}
      && flags.c == $past(mem_rdata[0]))
    else $error("rotate right through carry to working wrong");

  AST_SBC: assert property ( // RULE9
    s_go(alu_pkg::OP_BORROW_MINUS_TO_WORKING) |=> working_register ==
      8'($past(working_register) + ~$past(mem_rdata) + {7'h00, $past(flags.c)})
      && flags.z == (working_register == 8'h00))
    else $error("subtract with borrow wrong");

  AST_SUB_MEM: assert property ( // RULE10
    s_go(alu_pkg::OP_MINUS_TO_MEMORY) |=> (mem_we
      && mem_wdata == 8'($past(working_register) - $past(mem_rdata))) and s_keep_work)
    else $error("subtract to memory wrong");

  AST_SUB_CARRY: assert property ( // RULE19
    s_go(alu_pkg::OP_MINUS_TO_WORKING) |=>
      flags.c == ($past(working_register) >= $past(mem_rdata))
      && flags.ac == ($past(working_register[3:0]) >= $past(mem_rdata[3:0])))
    else $error("subtract carry flags wrong");

  AST_DEC_MEM: assert property ( // RULE11
    s_go(alu_pkg::OP_DEC_SKIP_ZERO) |=> (mem_we
      && mem_wdata == 8'($past(mem_rdata) - 8'h01)
      && flush == ($past(mem_rdata) == 8'h01)) and s_keep_flags)
    else $error("decrement skip zero wrong");

  AST_DEC_WORK: assert property ( // RULE12
    s_go(alu_pkg::OP_DEC_TO_WORKING_SKIP_ZERO) |=> !mem_we
      && working_register == 8'($past(mem_rdata) - 8'h01)
      && flush == ($past(mem_rdata) == 8'h01))
    else $error("decrement to working skip zero wrong");

  AST_INC_MEM: assert property ( // RULE13
    s_go(alu_pkg::OP_INC_SKIP_ZERO) |=> (mem_we
      && mem_wdata == 8'($past(mem_rdata) + 8'h01)
      && flush == ($past(mem_rdata) == 8'hFF)) and s_keep_flags)
    else $error("increment skip zero wrong");

  AST_INC_WORK: assert property ( // RULE14
    s_go(alu_pkg::OP_INC_TO_WORKING_SKIP_ZERO) |=> (!mem_we
      && working_register == 8'($past(mem_rdata) + 8'h01)
      && flush == ($past(mem_rdata) == 8'hFF)) and s_keep_flags)
    else $error("increment to working skip zero wrong");

  AST_BIT_SKIP: assert property ( // RULE15
    s_go(alu_pkg::OP_BIT_SET_SKIP) |=> (!mem_we
      && flush == $past(mem_rdata[exec_req.bit_sel])) and s_keep_flags)
    else $error("bit set skip wrong");

  AST_SKIP_DUMMY: assert property ( // RULE16
    flush |-> !exec_ready ##1 (exec_ready && !flush))
    else $error("skip dummy cycle wrong");

  AST_NO_SKIP: assert property ( // RULE16
    exec_req.valid && exec_ready ##1 !flush |-> exec_ready)
    else $error("ready dropped without skip");

  AST_BYTE_SET: assert property ( // RULE17
    s_go(alu_pkg::OP_BYTE_SET) |=> (mem_we && mem_wdata == 8'hFF) and s_keep_flags)
    else $error("byte set wrong");

  AST_BIT_SET: assert property ( // RULE18
    s_go(alu_pkg::OP_BIT_SET) |=> (mem_we
      && mem_wdata == ($past(mem_rdata) | (8'h01 << $past(exec_req.bit_sel))))
      and s_keep_flags)
    else $error("bit set wrong");

endmodule : rotate_subtract_skip_alu

// ===== rtl/alu_params.svh
// Offsets, field positions, reset values and counts of the rotate/subtract/skip ALU
// Operation
// [RULE1] Rotate memory left, bit 7 to bit 0
// [RULE2] Same left rotate, result to working register
// [RULE3] Rotate memory left through carry
// [RULE4] Left rotate through carry into working register
// [RULE5] Rotate memory right, bit 0 to bit 7
// [RULE6] Same right rotate, result to working register
// [RULE7] Rotate memory right through carry
// [RULE8] Right rotate through carry into working register
// [RULE9] Working plus inverted memory plus carry
// [RULE10] Working plus inverted memory plus one
// [RULE11] Decrement memory, skip when zero
// [RULE12] Decrement into working, skip when zero
// [RULE13] Increment memory, skip when zero
// [RULE14] Increment into working, skip when zero
// [RULE15] Skip when selected memory bit is one
// [RULE16] Skip discards prefetch, adds dummy cycle
// [RULE17] Byte set writes all ones
// [RULE18] Bit set forces selected bit only
// [RULE19] Subtract flags: carry, signed wrap, nibble carry
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH
`define WORK_OFS    6'h00
`define FLAGS_OFS   6'h01
`define STAT_OFS    6'h02
`define ADDR_LSB    2
`define ADDR_MSB    7
`define FLAG_C_POS  0
`define FLAG_AC_POS 1
`define FLAG_Z_POS  2
`define FLAG_OV_POS 3
`define STAT_BUSY_POS 0
`define STAT_SKIP_POS 1
`define WORK_RST    8'h00
`define FLAGS_RST   4'h0
`define SKIP_CYCLES 2
`define RUN_CYCLES  1
`endif

// ===== rtl/alu_pkg.sv
// Types shared by the rotate/subtract/skip ALU
package alu_pkg;
  typedef enum logic [4:0] {
    OP_ROTATE_LEFT_MEMORY,
    OP_ROTATE_LEFT_TO_WORKING,
    OP_ROTATE_LEFT_THRU_CARRY,
    OP_ROTATE_LEFT_THRU_CARRY_TO_WORKING,
    OP_ROTATE_RIGHT_MEMORY,
    OP_ROTATE_RIGHT_TO_WORKING,
    OP_ROTATE_RIGHT_THRU_CARRY,
    OP_ROTATE_RIGHT_THRU_CARRY_TO_WORKING,
    OP_BORROW_MINUS_TO_WORKING,
    OP_BORROW_MINUS_TO_MEMORY,
    OP_MINUS_TO_WORKING,
    OP_MINUS_TO_MEMORY,
    OP_DEC_SKIP_ZERO,
    OP_DEC_TO_WORKING_SKIP_ZERO,
    OP_INC_SKIP_ZERO,
    OP_INC_TO_WORKING_SKIP_ZERO,
    OP_BIT_SET_SKIP,
    OP_BYTE_SET,
    OP_BIT_SET
  } op_type;
  typedef enum logic {RUN, DUMMY} fsm_type;
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } flags_type;
  typedef struct packed {
    logic       valid;
    op_type     op;
    logic [2:0] bit_sel;
  } exec_req_type;
  typedef struct packed {
    fsm_type   fsm;
    logic      ready;
    logic      flush;
    logic      last_skip;
    logic [7:0] work;
    flags_type flags;
    logic      mem_we;
    logic [7:0] mem_wdata;
    logic      wr_pend;
    logic [5:0] wr_idx;
    logic [31:0] rdata;
    logic      hreadyout;
  } state_type;
endpackage : alu_pkg

// ===== verification/data_memory_model.sv
// Data memory model on the far side of the datapath
module data_memory_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bench preload and byte select
  input  wire logic       load_en,
  input  wire logic [7:0] load_data,
  input  wire logic [1:0] addr,
  input  wire logic       take,
  // Datapath side
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata,
  output logic [7:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bytes_r [4];
  logic [1:0] addr_r;
  // Read port follows the byte select at once
  assign mem_rdata = bytes_r[addr];
  // Byte of the accepted instruction is kept for its late write-back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 2'h0;
    end else if (take) begin
      addr_r <= addr;
    end
  end
  // Preload from the bench, write-back from the datapath
  always @(posedge hclk) begin
    if (load_en) bytes_r[addr] <= load_data;
    if (mem_we) bytes_r[addr_r] <= mem_wdata;
  end
endmodule : data_memory_model

// ===== verification/testbench.sv
// Self-checking bench of the rotate/subtract/skip datapath
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  hclk = 1'b0;
  logic                  hresetn = 1'b0;
  logic                  hsel = 1'b0;
  logic                  hwrite = 1'b0;
  logic [31:0]           haddr = 32'h0;
  logic [31:0]           hwdata = 32'h0;
  logic [1:0]            htrans = 2'h0;
  logic [2:0]            hsize = 3'h2;
  logic                  hready, hreadyout, hresp, exec_ready, flush, mem_we;
  logic [31:0]           hrdata;
  logic [7:0]            mem_wdata, working_register, mem_rdata;
  alu_pkg::flags_type    flags;
  alu_pkg::exec_req_type req = '0;
  logic                  load_en = 1'b0;
  logic [7:0]            load_data = 8'h00;
  logic [1:0]            addr = 2'h0;
  int                    miscompares = 0;
  int                    tests_run = 0;
  int                    cycles = 0;
  logic [7:0] vec_w [6] = '{8'h00, 8'h80, 8'h7F, 8'h35, 8'hFF, 8'h10};
  logic [7:0] vec_m [6] = '{8'h00, 8'h01, 8'hFF, 8'h80, 8'hA5, 8'h5A};
  logic [3:0] vec_f [6] = '{4'h0, 4'h1, 4'hF, 4'h1, 4'h0, 4'h1};
  assign hready = hreadyout;
  // Clock generation
  always #4 hclk = ~hclk;
  rotate_subtract_skip_alu u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .exec_req(req),
    .mem_rdata(mem_rdata), .exec_ready(exec_ready), .flush(flush), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .working_register(working_register), .flags(flags)
  );
  data_memory_model u_mem (
    .hclk(hclk), .hresetn(hresetn), .load_en(load_en), .load_data(load_data),
    .addr(addr), .take(req.valid & exec_ready), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );
  // Verdict and end of run
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  // One single-word transfer; read data taken at the closing edge
  task automatic ahb_cycle(input logic [31:0] a, input logic wr, input logic [31:0] d,
                           output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb_cycle
  // Preload the byte, issue one instruction, return where its results are settled
  task automatic run_op(input int idx, input logic [2:0] b, input logic [7:0] m);
    @(posedge hclk);
    load_en <= 1'b1;
    load_data <= m;
    addr <= b[1:0];
    @(posedge hclk);
    load_en <= 1'b0;
    req <= '{valid: 1'b1, op: alu_pkg::op_type'(idx), bit_sel: b};
    do @(posedge hclk); while (exec_ready !== 1'b1);
    req.valid <= 1'b0;
    @(negedge hclk);
  endtask : run_op
  // Expected results; indices follow the op_type order
  function automatic void ref_op(input int idx, input logic [2:0] b, input logic [7:0] m,
      inout logic [7:0] w, inout logic [3:0] f, output logic we, output logic [7:0] r,
      output logic skip);
    logic [8:0] s;
    logic [4:0] n;
    logic       cin;
    we = 1'b1;
    skip = 1'b0;
    r = m;
    cin = (idx >= 10) ? 1'b1 : f[0];
    case (idx)
      0, 1: r = {m[6:0], m[7]};
      2, 3: begin r = {m[6:0], f[0]}; f[0] = m[7]; end
      4, 5: r = {m[0], m[7:1]};
      6, 7: begin r = {f[0], m[7:1]}; f[0] = m[0]; end
      8, 9, 10, 11: begin
        s = {1'b0, w} + {1'b0, ~m} + {8'h00, cin};
        n = {1'b0, w[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cin};
        f = {(w[7] != m[7]) && (s[7] != w[7]), s[7:0] == 8'h00, n[4], s[8]};
        r = s[7:0];
      end
      12, 13: begin r = m - 8'h01; skip = (r == 8'h00); end
      14, 15: begin r = m + 8'h01; skip = (r == 8'h00); end
      16: begin we = 1'b0; skip = m[b]; end
      17: r = 8'hFF;
      default: r = m | (8'h01 << b);
    endcase
    if (idx inside {1, 3, 5, 7, 8, 10, 13, 15}) begin
      w = r;
      we = 1'b0;
    end
  endfunction : ref_op
  // Hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      miscompares++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic [7:0]  w;
    logic [7:0]  r;
    logic [3:0]  f;
    logic [2:0]  b;
    logic        we;
    logic        skip;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check_val({24'h0, working_register}, 32'h0);
    check_val({28'h0, flags}, 32'h0);
    check_bit(exec_ready, 1'b1);
    check_bit(flush, 1'b0);
    check_bit(mem_we, 1'b0);
    check_bit(hresp, 1'b0);
    // Register map: reset values, unmapped place, upper bits
    ahb_cycle(32'h4, 1'b0, 32'h0, rd);
    check_val(rd, 32'h0);
    ahb_cycle(32'h8, 1'b0, 32'h0, rd);
    check_val(rd, 32'h0);
    ahb_cycle(32'hC, 1'b1, 32'h55, rd);
    ahb_cycle(32'hC, 1'b0, 32'h0, rd);
    check_val(rd, 32'h0);
    ahb_cycle(32'h0, 1'b1, 32'h1234_56A5, rd);
    ahb_cycle(32'h0, 1'b0, 32'h0, rd);
    check_val(rd, 32'h0000_00A5);
    // Every operation against every operand set
    for (int v = 0; v < 6; v++) begin
      for (int i = 0; i < 19; i++) begin
        w = vec_w[v];
        f = vec_f[v];
        b = 3'(v + i);
        ahb_cycle(32'h0, 1'b1, {24'h0, w}, rd);
        ahb_cycle(32'h4, 1'b1, {28'h0, f}, rd);
        ref_op(i, b, vec_m[v], w, f, we, r, skip);
        run_op(i, b, vec_m[v]);
        check_val({24'h0, working_register}, {24'h0, w});
        check_val({28'h0, flags}, {28'h0, f});
        check_bit(mem_we, we);
        if (we) check_val({24'h0, mem_wdata}, {24'h0, r});
        check_bit(flush, skip);
        check_bit(exec_ready, !skip);
        @(negedge hclk);
        check_bit(exec_ready, 1'b1);
        check_bit(flush, 1'b0);
        check_val({24'h0, mem_rdata}, {24'h0, we ? r : vec_m[v]});
        ahb_cycle(32'h8, 1'b0, 32'h0, rd);
        check_val(rd, {30'h0, skip, 1'b0});
      end
    end
    complete_run();
  end
endmodule : testbench
